// >>> pmv_pkg.sv
// Shared constants, types and helpers for the program and data memory block.
package pmv_pkg;

  // Store geometry.
  localparam int PM_WORDS = 4096;
  localparam int PM_WIDTH = 15;
  localparam int PM_AW = 12;
  localparam int DM_WIDTH = 8;
  localparam int DM_WORDS = 256;
  localparam int DM_AW = 8;

  // Fixed entry points in the program store.
  localparam logic [11:0] RESET_VEC = 12'h000;
  localparam logic [11:0] VEC_EXT_FIRST = 12'h004;
  localparam logic [11:0] VEC_TIMER = 12'h008;
  localparam logic [11:0] VEC_ADC = 12'h00c;
  localparam logic [11:0] VEC_SER_A = 12'h010;
  localparam logic [11:0] VEC_SER_B = 12'h014;
  localparam logic [11:0] VEC_EXT_SECOND = 12'h018;

  // Interrupt source indexes; a lower index wins when several are pending.
  localparam int IRQ_N = 6;
  localparam int IRQ_EXT_FIRST = 0;
  localparam int IRQ_TIMER = 1;
  localparam int IRQ_ADC = 2;
  localparam int IRQ_SER_A = 3;
  localparam int IRQ_SER_B = 4;
  localparam int IRQ_EXT_SECOND = 5;

  // Table addressing.
  localparam logic [3:0] LAST_PAGE = 4'hf;

  // Data memory addresses handled by this block.
  localparam logic [7:0] ADDR_INDIRECT = 8'h00;
  localparam logic [7:0] ADDR_POINTER = 8'h01;
  localparam logic [7:0] ADDR_PCL = 8'h06;
  localparam logic [7:0] ADDR_TBLP = 8'h07;
  localparam logic [7:0] ADDR_TABLE_HIGH_HOLDING = 8'h08;
  localparam logic [7:0] GP_BASE = 8'h20;

  // Values after reset.
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [7:0] TBLP_RESET = 8'h00;
  localparam logic [7:0] TABLE_HIGH_HOLDING_RESET = 8'h00;
  localparam logic [14:0] INSTR_RESET = 15'h0000;

  // Timing: 250 MHz system clock, four clocks to one instruction cycle.
  localparam int CLK_PERIOD_NS = 4;
  localparam int CLKS_PER_INSTR = 4;
  localparam logic [1:0] PHASE_LAST = 2'(CLKS_PER_INSTR - 1);
  localparam int TBL_INSTR_CYCLES = 2;
  localparam int TBL_DONE_CLKS = TBL_INSTR_CYCLES * CLKS_PER_INSTR + 1;

  typedef enum {TBL_IDLE, TBL_FETCH, TBL_WRITE} pmv_tbl_state_t;
  typedef enum {DM_NONE, DM_READ, DM_WRITE, DM_SET, DM_CLR} pmv_dm_op_t;

  // Entry point of each interrupt source.
  function automatic logic [11:0] pmv_vector(input logic [2:0] idx);
    case (idx)
      3'h0: pmv_vector = VEC_EXT_FIRST;
      3'h1: pmv_vector = VEC_TIMER;
      3'h2: pmv_vector = VEC_ADC;
      3'h3: pmv_vector = VEC_SER_A;
      3'h4: pmv_vector = VEC_SER_B;
      3'h5: pmv_vector = VEC_EXT_SECOND;
      default: pmv_vector = RESET_VEC;
    endcase
  endfunction : pmv_vector

endpackage : pmv_pkg

// >>> pmv_ram.sv
// Synchronous memory with one write port and a registered read port.
`timescale 1ns/100ps
module pmv_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clk, // System clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic we, // Write enable.
  input wire logic [AW-1:0] waddr, // Write address.
  input wire logic [WIDTH-1:0] wdata, // Write data.
  input wire logic [AW-1:0] raddr, // Read address, sampled every clock.
  output logic [WIDTH-1:0] rdata_reg // Read data, one clock after the address.
);

  logic [WIDTH-1:0] mem [DEPTH];

  // The array has no reset so that it maps onto plain RAM.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read data always comes out of a register.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= mem[raddr];
    end
  end

endmodule : pmv_ram

// >>> pmv_core.sv
// Program counter, vectors, table lookup and data memory of the microcontroller core.
`timescale 1ns/100ps
module pmv_core
  import pmv_pkg::*;
(
  input wire logic clk, // System clock, 250 MHz.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic pc_load, // Load pc_target at the next cycle boundary.
  input wire logic [11:0] pc_target, // Branch target address.
  input wire logic pc_hold, // Keep the counter at the next cycle boundary.
  input wire logic irq_allow, // Sequencer can take an interrupt now.
  input wire logic stack_full, // All stack levels are in use.
  input wire logic [IRQ_N-1:0] irq_enable, // Per-source interrupt enables.
  input wire logic ext_irq_first_n, // First external interrupt pin.
  input wire logic ext_irq_second_n, // Second external interrupt pin.
  input wire logic timer_overflow, // Timer overflow pulse.
  input wire logic adc_done, // Conversion complete pulse.
  input wire logic ser_a_done, // First serial unit byte done pulse.
  input wire logic ser_b_done, // Second serial unit byte done pulse.
  input wire logic table_read_current_page, // Table read from the current page.
  input wire logic table_read_last_page, // Table read from the last page.
  input wire logic [7:0] tbl_dest, // Destination data address of a table read.
  input wire logic dm_req_read, // Data memory read request.
  input wire logic dm_req_write, // Data memory write request.
  input wire logic dm_req_set, // Data memory bit set request.
  input wire logic dm_req_clr, // Data memory bit clear request.
  input wire logic [7:0] dm_addr, // Data memory address.
  input wire logic [7:0] dm_wdata, // Data memory write data.
  input wire logic [2:0] dm_bit, // Bit index for set and clear.
  input wire logic pgm_we, // Program store load strobe.
  input wire logic [11:0] pgm_addr, // Program store load address.
  input wire logic [14:0] pgm_wdata, // Program store load word.
  output logic cycle_pulse_reg, // One clock at the end of each instruction cycle.
  output logic [11:0] pc_reg, // Program counter.
  output logic [14:0] instr_reg, // Word fetched at the program counter.
  output logic irq_ack_reg, // Interrupt acknowledge pulse.
  output logic [IRQ_N-1:0] irq_flags_reg, // Pending interrupt request flags.
  output logic [7:0] table_high_holding_reg, // Table high byte holding register.
  output logic tbl_done_reg, // Table read finished pulse.
  output logic [7:0] dm_rdata_reg, // Data memory read result.
  output logic dm_done_reg, // Data memory access finished pulse.
  output logic busy_reg // Requests are ignored while high.
);

  // Instruction cycle divider and enable.
  logic [1:0] phase_reg;
  wire cycle_en = cycle_pulse_reg;

  // Interrupt pins: three-flop synchronisers and a filtered level.
  logic [1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_lvl_reg;
  wire [1:0] pin_raw = {ext_irq_second_n, ext_irq_first_n};
  wire [1:0] pin_stable = ~(pin_s2_reg ^ pin_s3_reg);
  wire [1:0] pin_fall = pin_lvl_reg & pin_stable & ~pin_s3_reg;

  // Interrupt request and acknowledge.
  logic [2:0] ack_idx_reg;
  logic [2:0] sel_idx;
  wire [IRQ_N-1:0] irq_event = {pin_fall[1], ser_b_done, ser_a_done, adc_done, timer_overflow,
                                pin_fall[0]};
  wire [IRQ_N-1:0] irq_pend = irq_flags_reg & irq_enable;
  logic [IRQ_N-1:0] irq_clear;

  // Table lookup state.
  pmv_tbl_state_t tbl_state_reg;
  logic [7:0] tblp_reg;
  logic [11:0] tbl_addr_reg;
  logic [7:0] tbl_dest_reg;
  logic [14:0] tbl_word_reg;
  wire tbl_req = table_read_current_page | table_read_last_page;
  wire tbl_take = tbl_req & cycle_en & ~busy_reg & (tbl_state_reg == TBL_IDLE);
  wire tbl_cap = (tbl_state_reg == TBL_FETCH) & cycle_en;
  wire tbl_wr = (tbl_state_reg == TBL_WRITE) & cycle_en;
  wire [3:0] tbl_page = table_read_last_page ? LAST_PAGE : pc_reg[11:8];

  wire irq_take = cycle_en & irq_allow & ~stack_full & (|irq_pend)
                  & (tbl_state_reg == TBL_IDLE) & ~tbl_take;

  // Data memory access pipeline.
  logic [7:0] indirect_pointer_reg;
  logic pend_reg;
  pmv_dm_op_t pend_op_reg;
  logic [7:0] pend_addr_reg, pend_wdata_reg, pend_sfr_reg;
  logic [2:0] pend_bit_reg;
  wire dm_req = dm_req_read | dm_req_write | dm_req_set | dm_req_clr;
  wire dm_take = dm_req & ~busy_reg & ~tbl_take & (tbl_state_reg == TBL_IDLE);
  logic [14:0] prog_rdata;
  logic [7:0] ram_rdata;

  // Address zero stands for the location held in the pointer.
  function automatic logic [7:0] resolve(input logic [7:0] a, input logic [7:0] ptr);
    resolve = (a == ADDR_INDIRECT) ? ptr : a;
  endfunction : resolve

  wire [7:0] dm_eff = resolve(dm_addr, indirect_pointer_reg);
  wire take_gp = (dm_eff >= GP_BASE);

  // Special-function read value; anything not held here reads as zero.
  wire [7:0] sfr_val = (dm_eff == ADDR_POINTER) ? indirect_pointer_reg :
                       (dm_eff == ADDR_PCL) ? pc_reg[7:0] :
                       (dm_eff == ADDR_TBLP) ? tblp_reg :
                       (dm_eff == ADDR_TABLE_HIGH_HOLDING) ? table_high_holding_reg : 8'h00;

  // Second stage of an access: current value, locked bits and the result.
  wire pend_gp = (pend_addr_reg >= GP_BASE);
  wire [7:0] cur_val = pend_gp ? ram_rdata : pend_sfr_reg;
  wire [7:0] lock_mask = ((pend_addr_reg == ADDR_TABLE_HIGH_HOLDING) || (pend_addr_reg == ADDR_PCL))
                         ? 8'hff : 8'h00;
  wire [7:0] bit_mask = 8'(8'h01 << pend_bit_reg) & ~lock_mask;
  wire [7:0] op_result = (pend_op_reg == DM_SET) ? (cur_val | bit_mask) :
                         (pend_op_reg == DM_CLR) ? (cur_val & ~bit_mask) : pend_wdata_reg;
  wire pend_wr = pend_reg & (pend_op_reg != DM_READ) & (pend_op_reg != DM_NONE);

  // One write path for table results and data memory writes.
  wire wr_en = tbl_wr | pend_wr;
  wire [7:0] wr_addr = tbl_wr ? tbl_dest_reg : pend_addr_reg;
  wire [7:0] wr_data = tbl_wr ? tbl_word_reg[7:0] : op_result;
  wire ram_we = wr_en & (wr_addr >= GP_BASE);
  wire [11:0] prog_raddr = (tbl_state_reg == TBL_FETCH) ? tbl_addr_reg : pc_reg;

  // Instruction cycle divider: one enable pulse every four clocks.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= 2'h0;
      cycle_pulse_reg <= 1'b0;
    end else begin
      phase_reg <= 2'(phase_reg + 2'h1);
      cycle_pulse_reg <= (phase_reg == 2'(PHASE_LAST - 2'h1));
    end
  end

  // Pin synchronisers; a change counts once the second and third flops agree.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_reg <= 2'h3;
      pin_s2_reg <= 2'h3;
      pin_s3_reg <= 2'h3;
      pin_lvl_reg <= 2'h3;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_lvl_reg <= (pin_stable & pin_s3_reg) | (~pin_stable & pin_lvl_reg);
    end
  end

  // Lowest pending index wins; the vector order follows the index.
  always_comb begin
    sel_idx = 3'h0;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (irq_pend[i]) begin
        sel_idx = 3'(i);
      end
    end
  end

  // Flags stay set until acknowledged, so a full stack only delays service.
  generate
    for (genvar g = 0; g < IRQ_N; g++) begin : g_irq
      assign irq_clear[g] = irq_take & (sel_idx == 3'(g));
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          irq_flags_reg[g] <= 1'b0;
        end else begin
          irq_flags_reg[g] <= irq_event[g] | (irq_flags_reg[g] & ~irq_clear[g]);
        end
      end
    end
  endgenerate

  // Program counter: vectors first, then table stall, hold, branch and step.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pc_reg <= RESET_VEC;
      irq_ack_reg <= 1'b0;
      ack_idx_reg <= 3'h0;
    end else begin
      irq_ack_reg <= irq_take;
      if (irq_take) begin
        pc_reg <= pmv_vector(sel_idx);
        ack_idx_reg <= sel_idx;
      end else if (cycle_en && !tbl_take && tbl_state_reg == TBL_IDLE && !pc_hold) begin
        pc_reg <= pc_load ? pc_target : 12'(pc_reg + 12'h001);
      end
    end
  end

  // Instruction word is taken only when the store port is not lent to a table read.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      instr_reg <= INSTR_RESET;
    end else if (cycle_en && tbl_state_reg == TBL_IDLE) begin
      instr_reg <= prog_rdata;
    end
  end

  // Table read sequence: fetch for one instruction cycle, write in the next.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tbl_state_reg <= TBL_IDLE;
      tbl_addr_reg <= 12'h000;
      tbl_dest_reg <= 8'h00;
      tbl_word_reg <= 15'h0000;
      tbl_done_reg <= 1'b0;
    end else begin
      tbl_done_reg <= tbl_wr;
      case (tbl_state_reg)
        TBL_IDLE: begin
          if (tbl_take) begin
            tbl_state_reg <= TBL_FETCH;
            tbl_addr_reg <= {tbl_page, tblp_reg};
            tbl_dest_reg <= resolve(tbl_dest, indirect_pointer_reg);
          end
        end
        TBL_FETCH: begin
          if (cycle_en) begin
            tbl_word_reg <= prog_rdata;
            tbl_state_reg <= TBL_WRITE;
          end
        end
        TBL_WRITE: begin
          if (cycle_en) begin
            tbl_state_reg <= TBL_IDLE;
          end
        end
        default: tbl_state_reg <= TBL_IDLE;
      endcase
    end
  end

  // Holding register changes only on the capture of a table word.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      table_high_holding_reg <= TABLE_HIGH_HOLDING_RESET;
    end else if (tbl_cap) begin
      table_high_holding_reg <= {1'b0, prog_rdata[14:8]};
    end
  end

  // Pointer and table pointer take writes from either path.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      indirect_pointer_reg <= POINTER_RESET;
      tblp_reg <= TBLP_RESET;
    end else if (wr_en) begin
      if (wr_addr == ADDR_POINTER) begin
        indirect_pointer_reg <= wr_data;
      end
      if (wr_addr == ADDR_TBLP) begin
        tblp_reg <= wr_data;
      end
    end
  end

  // Access pipeline: address resolved on take, result one clock later.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_reg <= 1'b0;
      pend_op_reg <= DM_NONE;
      pend_addr_reg <= 8'h00;
      pend_wdata_reg <= 8'h00;
      pend_sfr_reg <= 8'h00;
      pend_bit_reg <= 3'h0;
    end else begin
      pend_reg <= dm_take;
      if (dm_take) begin
        pend_op_reg <= dm_req_write ? DM_WRITE : dm_req_set ? DM_SET :
                       dm_req_clr ? DM_CLR : DM_READ;
        pend_addr_reg <= dm_eff;
        pend_wdata_reg <= dm_wdata;
        pend_sfr_reg <= take_gp ? 8'h00 : sfr_val;
        pend_bit_reg <= dm_bit;
      end
    end
  end

  // Results and the busy flag; busy covers the second stage and a table read.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dm_rdata_reg <= 8'h00;
      dm_done_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      dm_done_reg <= pend_reg;
      busy_reg <= dm_take | tbl_take | ((tbl_state_reg != TBL_IDLE) & ~tbl_wr);
      if (pend_reg) begin
        dm_rdata_reg <= pend_wr ? op_result : cur_val;
      end
    end
  end

  // Program store: 4K words of 15 bits.
  pmv_ram #(.WIDTH(PM_WIDTH), .DEPTH(PM_WORDS), .AW(PM_AW)) u_prog (
    .clk(clk),
    .resetn(resetn),
    .we(pgm_we),
    .waddr(pgm_addr),
    .wdata(pgm_wdata),
    .raddr(prog_raddr),
    .rdata_reg(prog_rdata)
  );

  // General-purpose data memory, indexed by the full data address.
  pmv_ram #(.WIDTH(DM_WIDTH), .DEPTH(DM_WORDS), .AW(DM_AW)) u_data (
    .clk(clk),
    .resetn(resetn),
    .we(ram_we),
    .waddr(wr_addr),
    .wdata(wr_data),
    .raddr(dm_eff),
    .rdata_reg(ram_rdata)
  );

  // Checks on the behaviour above.
  vector_load_a: assert property (@(posedge clk) disable iff (!resetn)
    irq_ack_reg |-> (pc_reg == pmv_vector(ack_idx_reg) && $past(irq_pend[sel_idx])))
    else $error("Acknowledged interrupt did not load its vector.");
  stack_full_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    (stack_full && cycle_en && (irq_pend != '0)) |=> (!irq_ack_reg && irq_flags_reg != '0))
    else $error("Interrupt taken or lost while the stack was full.");
  serial_vector_a: assert property (@(posedge clk) disable iff (!resetn)
    (irq_take && sel_idx == 3'(IRQ_SER_A) && !ser_a_done)
    |=> (pc_reg == VEC_SER_A && !irq_flags_reg[IRQ_SER_A]))
    else $error("First serial unit did not vector correctly.");
  table_addr_a: assert property (@(posedge clk) disable iff (!resetn)
    tbl_take |=> (tbl_addr_reg == {$past(tbl_page), $past(tblp_reg)}
                  && (tbl_addr_reg[11:8] == LAST_PAGE || !$past(table_read_last_page))))
    else $error("Table address not built from page and pointer.");
  table_timing_a: assert property (@(posedge clk) disable iff (!resetn)
    tbl_take |-> ##9 tbl_done_reg)
    else $error("Table read did not finish in two instruction cycles.");
  holding_zero_a: assert property (@(posedge clk) disable iff (!resetn)
    table_high_holding_reg[7] == 1'b0)
    else $error("Unused holding bit is not zero.");
  holding_readonly_a: assert property (@(posedge clk) disable iff (!resetn)
    $changed(table_high_holding_reg) |-> $past(tbl_cap))
    else $error("Holding register changed outside a table read.");
  table_split_a: assert property (@(posedge clk) disable iff (!resetn)
    tbl_cap |=> (table_high_holding_reg[6:0] == tbl_word_reg[14:8]))
    else $error("Table high part not placed in the holding register.");
  unused_sfr_a: assert property (@(posedge clk) disable iff (!resetn)
    (dm_take && dm_req_read && !take_gp && dm_eff != ADDR_POINTER && dm_eff != ADDR_PCL
     && dm_eff != ADDR_TBLP && dm_eff != ADDR_TABLE_HIGH_HOLDING) |=> ##1 (dm_rdata_reg == 8'h00))
    else $error("Unused special address did not read zero.");
  reset_vector_a: assert property (@(posedge clk)
    !resetn |=> (pc_reg == RESET_VEC))
    else $error("Counter not at location zero after reset.");

endmodule : pmv_core

// >>> pmv_seq_model.sv
// Behavioural model of the sequencer's stack depth and its interrupt permission.
`timescale 1ns/100ps
module pmv_seq_model (
  input wire logic clk, // System clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic irq_ack_reg, // Acknowledge from the core, pushes one level.
  input wire logic ret, // Return instruction, pops one level.
  output logic irq_allow, // Interrupts may be taken now.
  output logic stack_full // All six levels are in use.
);
  logic [2:0] depth_reg;
  // Only the depth is kept; a pop on an empty stack is ignored rather than wrapping.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      depth_reg <= 3'h0;
    end else if (irq_ack_reg && !ret && depth_reg != 3'h6) begin
      depth_reg <= depth_reg + 3'h1;
    end else if (ret && !irq_ack_reg && depth_reg != 3'h0) begin
      depth_reg <= depth_reg - 3'h1;
    end
  end
  // Six levels in use hold acknowledge off until a return frees one.
  assign stack_full = (depth_reg == 3'h6);
  assign irq_allow = resetn;
endmodule : pmv_seq_model

// >>> tb_pmv_core.sv
// Self-checking testbench for the program and data memory core.
`timescale 1ns/100ps
module tb_pmv_core;
  import pmv_pkg::*;
  logic clk, resetn, pc_load, pc_hold, irq_allow, stack_full, ret, pgm_we;
  logic ext_irq_first_n, ext_irq_second_n, timer_overflow, adc_done, ser_a_done, ser_b_done;
  logic table_read_current_page, table_read_last_page;
  logic dm_req_read, dm_req_write, dm_req_set, dm_req_clr;
  logic [11:0] pc_target, pgm_addr, pc_reg;
  logic [14:0] pgm_wdata, instr_reg;
  logic [IRQ_N-1:0] irq_enable, irq_flags_reg;
  logic [7:0] tbl_dest, dm_addr, dm_wdata, table_high_holding_reg, dm_rdata_reg;
  logic [2:0] dm_bit;
  logic cycle_pulse_reg, irq_ack_reg, tbl_done_reg, dm_done_reg, busy_reg;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [11:0] vec [6] = '{VEC_EXT_FIRST, VEC_TIMER, VEC_ADC, VEC_SER_A, VEC_SER_B,
    VEC_EXT_SECOND};

  pmv_core pmv_core_inst (.*);
  pmv_seq_model pmv_seq_model_inst (.clk(clk), .resetn(resetn), .irq_ack_reg(irq_ack_reg),
    .ret(ret), .irq_allow(irq_allow), .stack_full(stack_full));

  // Free-running clock; a cycle ceiling catches a hang long after the tests should end.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Waits a bounded number of clocks for a flag; a missing flag counts as a mismatch.
  task automatic wait_hi(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (s !== 1'b1) chk(16'h0, 16'h1);
  endtask : wait_hi

  // Op is {write, set, clear, read}; the request stands for exactly one edge.
  task automatic dm(input logic [3:0] op, input logic [7:0] a, d, input logic [2:0] b);
    @(posedge clk);
    {dm_req_write, dm_req_set, dm_req_clr, dm_req_read, dm_addr, dm_wdata, dm_bit} <= {op, a, d, b};
    @(posedge clk);
    {dm_req_write, dm_req_set, dm_req_clr, dm_req_read} <= 4'h0;
    wait_hi(dm_done_reg, 4);
  endtask : dm

  task automatic pgm(input logic [11:0] a, input logic [14:0] w);
    @(posedge clk);
    {pgm_we, pgm_addr, pgm_wdata} <= {1'b1, a, w};
    @(posedge clk);
    pgm_we <= 1'b0;
  endtask : pgm

  task automatic t_data();
    dm(4'h8, 8'h40, 8'ha5, 3'h0);
    dm(4'h1, 8'h40, 8'h00, 3'h0);
    chk(dm_rdata_reg, 8'ha5);
    dm(4'h4, 8'h40, 8'h00, 3'h1);
    chk(dm_rdata_reg, 8'ha7);
    dm(4'h2, 8'h40, 8'h00, 3'h7);
    chk(dm_rdata_reg, 8'h27);
    dm(4'h8, ADDR_POINTER, 8'h40, 3'h0);
    dm(4'h1, ADDR_INDIRECT, 8'h00, 3'h0);
    chk(dm_rdata_reg, 8'h27);
    dm(4'h8, ADDR_INDIRECT, 8'h5a, 3'h0);
    dm(4'h1, 8'h40, 8'h00, 3'h0);
    chk(dm_rdata_reg, 8'h5a);
    dm(4'h8, ADDR_TABLE_HIGH_HOLDING, 8'hff, 3'h0);
    dm(4'h1, ADDR_TABLE_HIGH_HOLDING, 8'h00, 3'h0);
    chk(dm_rdata_reg, 8'h00);
    dm(4'h8, 8'h0b, 8'h33, 3'h0);
    dm(4'h1, 8'h0b, 8'h00, 3'h0);
    chk(dm_rdata_reg, 8'h00);
    dm(4'h8, 8'hff, 8'hc3, 3'h0);
    dm(4'h1, 8'hff, 8'h00, 3'h0);
    chk(dm_rdata_reg, 8'hc3);
  endtask : t_data

  // One table read; the request level stands until the done pulse has been seen.
  task automatic tbl(input logic last, input logic [7:0] dest, input logic [14:0] w);
    int n;
    n = 0;
    @(posedge clk);
    {table_read_last_page, table_read_current_page, tbl_dest} <= {last, !last, dest};
    wait_hi(busy_reg, 8);
    while (tbl_done_reg !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(n), 16'h8);
    chk(table_high_holding_reg, {1'b0, w[14:8]});
    @(posedge clk);
    {table_read_last_page, table_read_current_page} <= 2'h0;
    dm(4'h1, dest, 8'h00, 3'h0);
    chk(dm_rdata_reg, w[7:0]);
  endtask : tbl

  task automatic t_table();
    pgm(12'hf06, 15'h5a1b);
    pgm(12'h534, 15'h7fe8);
    pgm(12'hf34, 15'h1111);
    dm(4'h8, ADDR_TBLP, 8'h06, 3'h0);
    tbl(1'b1, 8'h30, 15'h5a1b);
    @(posedge clk);
    {pc_load, pc_target} <= {1'b1, 12'h534};
    #1;
    wait_hi(cycle_pulse_reg, 8);
    @(posedge clk);
    pc_load <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(instr_reg, 15'h7fe8);
    dm(4'h8, ADDR_TBLP, 8'h34, 3'h0);
    tbl(1'b0, 8'h31, 15'h7fe8);
  endtask : t_table

  // Fires each source in turn; the model's stack fills to six on the last acknowledge.
  task automatic t_irq();
    for (int i = 0; i < IRQ_N; i++) begin
      @(posedge clk);
      {ser_b_done, ser_a_done, adc_done, timer_overflow} <= 4'((6'h1 << i) >> 1);
      {ext_irq_first_n, ext_irq_second_n} <= {i != 0, i != 5};
      @(posedge clk);
      {ser_b_done, ser_a_done, adc_done, timer_overflow} <= 4'h0;
      wait_hi(irq_ack_reg, 40);
      chk(pc_reg, vec[i]);
      @(posedge clk);
      {ext_irq_first_n, ext_irq_second_n} <= 2'h3;
    end
  endtask : t_irq

  task automatic t_full();
    int acks;
    acks = 0;
    @(posedge clk);
    timer_overflow <= 1'b1;
    @(posedge clk);
    timer_overflow <= 1'b0;
    repeat (24) begin
      @(posedge clk);
      #1;
      acks += int'(irq_ack_reg === 1'b1);
    end
    chk(16'(acks), 16'h0);
    chk(irq_flags_reg[IRQ_TIMER], 1'b1);
    @(posedge clk);
    {ret, irq_enable} <= {1'b1, 6'h3d};
    @(posedge clk);
    ret <= 1'b0;
    repeat (12) begin
      @(posedge clk);
      #1;
      acks += int'(irq_ack_reg === 1'b1);
    end
    chk(16'(acks), 16'h0);
    @(posedge clk);
    irq_enable <= '1;
    wait_hi(irq_ack_reg, 12);
    chk(pc_reg, VEC_TIMER);
  endtask : t_full

  task automatic complete_run();
    $display("Mismatches %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  // Main sequence: reset for eight clocks, then each scenario in turn.
  initial begin
    {resetn, pc_load, pc_hold, ret, pgm_we, timer_overflow, adc_done, ser_a_done} = 8'h0;
    {ser_b_done, table_read_current_page, table_read_last_page} = 3'h0;
    {dm_req_read, dm_req_write, dm_req_set, dm_req_clr, dm_bit} = 7'h0;
    {pc_target, pgm_addr, pgm_wdata, tbl_dest, dm_addr, dm_wdata} = '0;
    {ext_irq_first_n, ext_irq_second_n} = 2'h3;
    irq_enable = '1;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk(pc_reg, RESET_VEC);
    t_data();
    t_table();
    t_irq();
    t_full();
    complete_run();
  end
endmodule : tb_pmv_core
